/* design/sdp_packer.sv */
/*
 * sdp_packer: serial byte packer that cuts the byte stream into network
 * frames, plus the udp packet-command parser.
 * assumes: serial bytes are held on valid until ser_ready_o takes them; the network path
 * takes beats with valid/ready; software uses the plain register port.
 */
// Overview of operation
// - length zero: no size limit
// - release frame when count reaches length
// - no delimiters: forward every byte immediately
// - delimiters: hold bytes until delimiter seen
// - delimiter value zero means unused
// - full 1K buffer releases frame
// - match one: either delimiter ends frame
// - match two: first then second delimiter
// - process option needs first delimiter enabled
// - do-nothing: release at delimiter
// - plus-one: release after one more byte
// - plus-two: release after two more bytes
// - force time zero: no idle timeout
// - idle milliseconds elapsed: release frame
// - udp raw four destinations, or command
// - command: 02, ip, length, payload
// - command destination port is listen port
`timescale 1ns/100ps
`default_nettype none
module sdp_packer
    import sdp_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            ser_data_i,
    input  wire logic                  ser_valid_i,
    output logic                       ser_ready_o,
    output sdp_pkg::sdp_beat_t         net_beat_o,
    output logic                       net_valid_o,
    input  wire logic                  net_ready_i,
    input  wire logic [3:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o
);
    import sdp_pkg::*;

    ////////////////////////////
    // registers

    logic [10:0] pkt_len;
    logic [7:0]  delim1;
    logic [7:0]  delim2;
    logic [6:0]  opts;
    logic [15:0] force_ms;
    logic [31:0] dest_ip [4];
    logic [15:0] listen_port;
    logic [31:0] cmd_ip;
    logic [10:0] buf_count;
    logic        held_flag;

    logic        match2;
    logic [1:0]  proc_opt;
    logic        udp_mode;
    logic        pkt_cmd;
    logic [1:0]  dest_sel;

    assign match2   = opts[SDP_OPT_MATCH2];
    assign proc_opt = opts[SDP_OPT_PROC_LO +: 2];
    assign udp_mode = opts[SDP_OPT_UDP];
    assign pkt_cmd  = opts[SDP_OPT_PKTCMD];
    assign dest_sel = opts[SDP_OPT_DSEL_LO +: 2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pkt_len     <= SDP_RST_PKTLEN;
            delim1      <= SDP_RST_DELIM[7:0];
            delim2      <= SDP_RST_DELIM[15:8];
            opts        <= SDP_RST_OPTS;
            force_ms    <= SDP_RST_FORCE;
            listen_port <= SDP_RST_LPORT;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                SDP_REG_PKTLEN: begin
                    // lengths above 1024 clamp to the buffer size
                    pkt_len <= (reg_wdata_i[10:0] > 11'h400) ? 11'h400
                                                             : reg_wdata_i[10:0];
                end
                SDP_REG_DELIM: begin
                    delim1 <= reg_wdata_i[7:0];
                    delim2 <= reg_wdata_i[15:8];
                end
                SDP_REG_OPTS:  opts        <= reg_wdata_i[6:0];
                SDP_REG_FORCE: force_ms    <= reg_wdata_i[15:0];
                SDP_REG_LPORT: listen_port <= reg_wdata_i[15:0];
                default: begin
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dest
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    dest_ip[gi] <= 32'h00000000;
                end else if (reg_wr_i && reg_addr_i == SDP_REG_DEST0 + 4'(gi)) begin
                    dest_ip[gi] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                SDP_REG_PKTLEN: reg_rdata_o <= {21'h000000, pkt_len};
                SDP_REG_DELIM:  reg_rdata_o <= {16'h0000, delim2, delim1};
                SDP_REG_OPTS:   reg_rdata_o <= {25'h0000000, opts};
                SDP_REG_FORCE:  reg_rdata_o <= {16'h0000, force_ms};
                SDP_REG_DEST0, SDP_REG_DEST0 + 4'h1, SDP_REG_DEST0 + 4'h2,
                SDP_REG_DEST0 + 4'h3: reg_rdata_o <= dest_ip[reg_addr_i[1:0]];
                SDP_REG_LPORT:  reg_rdata_o <= {16'h0000, listen_port};
                SDP_REG_STATUS: reg_rdata_o <= {20'h00000, held_flag, buf_count};
                SDP_REG_CURIP:  reg_rdata_o <= cmd_ip;
                default:        reg_rdata_o <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////
    // packet-command parser

    sdp_cmd_t    cmd_state;
    logic [1:0]  ip_idx;
    logic [15:0] cmd_len;
    logic        fifo_ready;
    logic        take;
    logic        cmd_mode;
    logic        payload;

    assign cmd_mode    = udp_mode && pkt_cmd;
    assign ser_ready_o = fifo_ready;
    assign take        = ser_valid_i && fifo_ready;
    // framing bytes are consumed, only payload reaches the packer
    assign payload     = take && (!cmd_mode || cmd_state == SDP_CMD_DATA);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_state <= SDP_CMD_START;
            ip_idx    <= 2'h0;
            cmd_len   <= 16'h0000;
            cmd_ip    <= 32'h00000000;
        end else if (!cmd_mode) begin
            cmd_state <= SDP_CMD_START;
        end else if (take) begin
            case (cmd_state)
                SDP_CMD_START: begin
                    // stray bytes before a start byte are dropped
                    if (ser_data_i == SDP_START_BYTE) begin
                        cmd_state <= SDP_CMD_IP;
                        ip_idx    <= 2'h0;
                    end
                end
                SDP_CMD_IP: begin
                    cmd_ip <= {cmd_ip[23:0], ser_data_i};
                    ip_idx <= ip_idx + 2'h1;
                    if (ip_idx == 2'h3) begin
                        cmd_state <= SDP_CMD_LENH;
                    end
                end
                SDP_CMD_LENH: begin
                    cmd_len[15:8] <= ser_data_i;
                    cmd_state     <= SDP_CMD_LENL;
                end
                SDP_CMD_LENL: begin
                    cmd_len[7:0] <= ser_data_i;
                    cmd_state    <= ({cmd_len[15:8], ser_data_i} == 16'h0000)
                                    ? SDP_CMD_START : SDP_CMD_DATA;
                end
                SDP_CMD_DATA: begin
                    cmd_len <= cmd_len - 16'h0001;
                    if (cmd_len == 16'h0001) begin
                        cmd_state <= SDP_CMD_START;
                    end
                end
                default: cmd_state <= SDP_CMD_START;
            endcase
        end
    end

    ////////////////////////////
    // release decision

    logic        d1_en;
    logic        d2_en;
    logic        delim_on;
    logic        prev_d1;
    logic        delim_hit;
    logic [1:0]  tail_left;
    logic        in_tail;
    logic        hit_len;
    logic        hit_full;
    logic        hit_delim;
    logic        cmd_end;
    logic        last_byte;
    logic [15:0] ms_count;
    logic [14:0] cyc_count;
    logic        idle_flush;
    logic        flush_valid;

    assign d1_en    = (delim1 != 8'h00);
    assign d2_en    = (delim2 != 8'h00);
    assign delim_on = d1_en || d2_en;

    always_comb begin
        delim_hit = 1'b0;
        if (d1_en && d2_en && match2) begin
            delim_hit = prev_d1 && ser_data_i == delim2;
        end else if (d1_en && d2_en) begin
            delim_hit = ser_data_i == delim1 || ser_data_i == delim2;
        end else if (d1_en) begin
            delim_hit = ser_data_i == delim1;
        end else if (d2_en) begin
            delim_hit = ser_data_i == delim2;
        end
    end

    assign hit_len   = pkt_len != 11'h000 && buf_count + 11'h001 >= pkt_len;
    assign hit_full  = buf_count + 11'h001 == 11'(SDP_BUF_BYTES);
    assign cmd_end   = cmd_mode && cmd_len == 16'h0001;
    // tail extension only applies once the first delimiter is in use
    assign hit_delim = delim_hit && !in_tail &&
                       (proc_opt == SDP_PROC_NONE || !d1_en);
    assign last_byte = !delim_on || hit_len || hit_full || hit_delim || cmd_end
                       || (in_tail && tail_left == 2'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_d1   <= 1'b0;
            in_tail   <= 1'b0;
            tail_left <= 2'h0;
        end else if (payload) begin
            prev_d1 <= ser_data_i == delim1 && !in_tail;
            if (last_byte) begin
                in_tail <= 1'b0;
            end else if (in_tail) begin
                tail_left <= tail_left - 2'h1;
            end else if (delim_hit && d1_en) begin
                in_tail   <= 1'b1;
                tail_left <= (proc_opt == SDP_PROC_PLUS2) ? 2'h2 : 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_count <= 11'h000;
            held_flag <= 1'b0;
        end else if (payload) begin
            buf_count <= last_byte ? 11'h000 : buf_count + 11'h001;
            held_flag <= !last_byte;
        end else if (idle_flush) begin
            buf_count <= 11'h000;
            held_flag <= 1'b0;
        end
    end

    // idle timer restarts on every byte; 1 ms prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i || payload || !held_flag) begin
            cyc_count <= 15'h0000;
            ms_count  <= 16'h0000;
        end else if (cyc_count == 15'(SDP_MS_CYCLES - 1)) begin
            cyc_count <= 15'h0000;
            ms_count  <= ms_count + 16'h0001;
        end else begin
            cyc_count <= cyc_count + 15'h0001;
        end
    end

    assign idle_flush = held_flag && !payload && force_ms != 16'h0000
                        && ms_count == force_ms && fifo_ready;

    ////////////////////////////
    // output path

    sdp_beat_t beat_in;
    sdp_beat_t fifo_beat;
    logic      fifo_valid;

    assign flush_valid = payload || idle_flush;

    always_comb begin
        beat_in.data      = payload ? ser_data_i : 8'h00;
        // an idle flush emits a zero-data marker beat carrying last
        beat_in.last      = payload ? last_byte : 1'b1;
        beat_in.dest_ip   = cmd_mode ? cmd_ip : dest_ip[dest_sel];
        beat_in.dest_port = listen_port;
    end

    sdp_fifo #(
        .WIDTH (SDP_BEAT_W),
        .DEPTH (SDP_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (beat_in),
        .in_valid_i  (flush_valid),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_beat),
        .out_valid_o (fifo_valid),
        .out_ready_i (net_ready_i)
    );

    assign net_beat_o  = fifo_beat;
    assign net_valid_o = fifo_valid;
endmodule
`default_nettype wire

/* design/sdp_pkg.sv */
/*
 * sdp_pkg: constants and carrier types for the serial data packer.
 * assumes: one 25 MHz clock, synchronous active-high reset.
 */
package sdp_pkg;

    localparam int          SDP_CLK_HZ       = 25000000;
    localparam int          SDP_TICK_MS      = 1;
    localparam int          SDP_MS_CYCLES    = SDP_CLK_HZ / 1000 * SDP_TICK_MS;
    localparam int          SDP_BUF_BYTES    = 1024;
    localparam int          SDP_CNT_W        = 11;
    localparam int          SDP_FIFO_DEPTH   = 8;

    // register offsets on the plain register port
    localparam logic [3:0]  SDP_REG_PKTLEN   = 4'h0;
    localparam logic [3:0]  SDP_REG_DELIM    = 4'h1;
    localparam logic [3:0]  SDP_REG_OPTS     = 4'h2;
    localparam logic [3:0]  SDP_REG_FORCE    = 4'h3;
    localparam logic [3:0]  SDP_REG_DEST0    = 4'h4;
    localparam logic [3:0]  SDP_REG_LPORT    = 4'h8;
    localparam logic [3:0]  SDP_REG_STATUS   = 4'h9;
    localparam logic [3:0]  SDP_REG_CURIP    = 4'hA;

    // field positions in the options register
    localparam int          SDP_OPT_MATCH2   = 0;
    localparam int          SDP_OPT_PROC_LO  = 1;
    localparam int          SDP_OPT_UDP      = 3;
    localparam int          SDP_OPT_PKTCMD   = 4;
    localparam int          SDP_OPT_DSEL_LO  = 5;

    // reset values
    localparam logic [10:0] SDP_RST_PKTLEN   = 11'h000;
    localparam logic [15:0] SDP_RST_DELIM    = 16'h0000;
    localparam logic [6:0]  SDP_RST_OPTS     = 7'h01;
    localparam logic [15:0] SDP_RST_FORCE    = 16'h0000;
    localparam logic [15:0] SDP_RST_LPORT    = 16'h0FA1;

    localparam logic [7:0]  SDP_START_BYTE   = 8'h02;
    localparam logic [1:0]  SDP_PROC_NONE    = 2'h0;
    localparam logic [1:0]  SDP_PROC_PLUS1   = 2'h1;
    localparam logic [1:0]  SDP_PROC_PLUS2   = 2'h2;

    typedef enum logic [2:0] {
        SDP_CMD_START = 3'h0,
        SDP_CMD_IP    = 3'h1,
        SDP_CMD_LENH  = 3'h3,
        SDP_CMD_LENL  = 3'h2,
        SDP_CMD_DATA  = 3'h6
    } sdp_cmd_t;

    // one byte toward the network path
    typedef struct packed {
        logic [7:0]  data;
        logic        last;
        logic [31:0] dest_ip;
        logic [15:0] dest_port;
    } sdp_beat_t;

    localparam int          SDP_BEAT_W       = $bits(sdp_beat_t);

endpackage

/* design/sdp_fifo.sv */
/*
 * sdp_fifo: small flip-flop fifo, valid/ready on both sides.
 * assumes: single clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module sdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && (count != (AW+1)'(DEPTH));
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* dv/sdp_packer_checker.sv */
/* sdp_packer_checker: port assertions for sdp_packer.
 * assumes: bound to sdp_packer; settings change only while no frame is open. */
`timescale 1ns/100ps
`default_nettype none
module sdp_packer_checker (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic [7:0]         ser_data_i,
    input wire logic               ser_valid_i,
    input wire logic               ser_ready_o,
    input wire sdp_pkg::sdp_beat_t net_beat_o,
    input wire logic               net_valid_o,
    input wire logic               net_ready_i,
    input wire logic [3:0]         reg_addr_i,
    input wire logic [31:0]        reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o
);
    import sdp_pkg::*;
    logic [10:0] c_len, fcnt;
    logic [15:0] c_dl, c_frc, c_lp;
    logic [6:0]  c_op;
    logic [7:0]  prv;
    logic        plain, endb;
    ////////////////////////////
    // settings mirrored from the register port, no read-back trusted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_len <= SDP_RST_PKTLEN;
            c_dl  <= SDP_RST_DELIM;
            c_op  <= SDP_RST_OPTS;
            c_frc <= SDP_RST_FORCE;
            c_lp  <= SDP_RST_LPORT;
        end else if (reg_wr_i) begin
            if (reg_addr_i == SDP_REG_PKTLEN) c_len <= reg_wdata_i[10:0];
            if (reg_addr_i == SDP_REG_DELIM) c_dl <= reg_wdata_i[15:0];
            if (reg_addr_i == SDP_REG_OPTS) c_op <= reg_wdata_i[6:0];
            if (reg_addr_i == SDP_REG_FORCE) c_frc <= reg_wdata_i[15:0];
            if (reg_addr_i == SDP_REG_LPORT) c_lp <= reg_wdata_i[15:0];
        end
    end
    // beats already taken in the open frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fcnt <= 11'h000;
            prv  <= 8'h00;
        end else if (net_valid_o && net_ready_i) begin
            fcnt <= net_beat_o.last ? 11'h000 : fcnt + 11'h001;
            prv  <= net_beat_o.data;
        end
    end
    // plain delimiter framing; full-buffer cut excluded
    assign plain = c_len == 11'h000 && c_frc == 16'h0000 && !c_op[SDP_OPT_PKTCMD]
                   && c_op[SDP_OPT_PROC_LO +: 2] == SDP_PROC_NONE;
    assign endb = net_valid_o && net_beat_o.last && fcnt != 11'h3FF && plain;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////
    hold_beat_a: assert property (net_valid_o && !net_ready_i |=> net_valid_o && $stable(net_beat_o))
        else $error("beat changed while stalled");
    pass_through_a: assert property (ser_valid_i && ser_ready_o && c_dl == 16'h0000
        && !c_op[SDP_OPT_PKTCMD] && !net_valid_o |=> net_valid_o && net_beat_o.last
        && net_beat_o.data == $past(ser_data_i)) else $error("byte not forwarded at once");
    frame_len_a: assert property (net_valid_o && c_len != 11'h000 && !c_op[SDP_OPT_PKTCMD]
        |-> fcnt < c_len) else $error("frame longer than length setting");
    buf_full_a: assert property (net_valid_o |-> fcnt < 11'h400)
        else $error("frame longer than buffer");
    match_two_a: assert property (endb && c_op[SDP_OPT_MATCH2] && c_dl[7:0] != 8'h00
        && c_dl[15:8] != 8'h00 |-> net_beat_o.data == c_dl[15:8] && prv == c_dl[7:0])
        else $error("frame end without delimiter pair");
    match_one_a: assert property (endb && (!c_op[SDP_OPT_MATCH2] || c_dl[7:0] == 8'h00)
        && c_dl != 16'h0000 |-> (c_dl[7:0] != 8'h00 && net_beat_o.data == c_dl[7:0])
        || (c_dl[15:8] != 8'h00 && net_beat_o.data == c_dl[15:8]))
        else $error("frame end without a delimiter");
    delim_read_a: assert property (reg_rd_i && reg_addr_i == SDP_REG_DELIM
        |=> reg_rdata_o[15:0] == c_dl) else $error("delimiter read back wrong");
    cmd_port_a: assert property (net_valid_o && c_op[SDP_OPT_UDP] && c_op[SDP_OPT_PKTCMD]
        |-> net_beat_o.dest_port == c_lp) else $error("command port not listen port");
endmodule
bind sdp_packer sdp_packer_checker sdp_packer_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ser_data_i(ser_data_i), .ser_valid_i(ser_valid_i),
    .ser_ready_o(ser_ready_o), .net_beat_o(net_beat_o), .net_valid_o(net_valid_o),
    .net_ready_i(net_ready_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

/* dv/sdp_host.sv */
/* sdp_host: serial host model, sends queued bytes on a valid/ready strobe.
 * assumes: byte held until taken; line toggles while idle. */
`timescale 1ns/100ps
`default_nettype none
module sdp_host (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      ser_ready_i,
    output var  logic [7:0] ser_data_o,
    output var  logic      ser_valid_o
);
    logic [7:0] q[$];
    function automatic void put(input logic [7:0] b);
        q.push_back(b);
    endfunction
    function automatic bit busy();
        return q.size() != 0 || ser_valid_o;
    endfunction
    initial begin
        ser_valid_o = 1'b0;
        ser_data_o  = 8'hA5;
    end
    // bytes back to back, far inside any idle interval
    always @(posedge clk_i) begin
        if (rst_i || !ser_valid_o || ser_ready_i) begin
            if (!rst_i && q.size() != 0) begin
                ser_valid_o <= 1'b1;
                ser_data_o  <= q.pop_front();
            end else begin
                // idle line never keeps the last byte
                ser_valid_o <= 1'b0;
                ser_data_o  <= ~ser_data_o;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
/* tb: self-checking bench for sdp_packer, beats compared with a queue model.
 * assumes: sdp_host feeds bytes; the checker is bound in its own file. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sdp_pkg::*;
    logic        clk_i, rst_i, ser_valid, ser_ready, net_valid, net_ready, reg_wr, reg_rd, m2;
    logic [7:0]  ser_data, d1, d2, prv;
    sdp_beat_t   beat;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rs, v;
    int          n_fail, n_checks, cyc, cnt, tail, proc, plen, i, p;
    logic [58:0] exq[$], ev;
    logic [1:0]  chk, dsel;
    logic [15:0] lp;
    logic [31:0] dip[4];
    sdp_packer sdp_packer_inst (.clk_i(clk_i), .rst_i(rst_i), .ser_data_i(ser_data),
        .ser_valid_i(ser_valid), .ser_ready_o(ser_ready), .net_beat_o(beat),
        .net_valid_o(net_valid), .net_ready_i(net_ready), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
    sdp_host sdp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ser_ready_i(ser_ready),
        .ser_data_o(ser_data), .ser_valid_o(ser_valid));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    ////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // 40..7F never hits a delimiter or zero
    function automatic logic [7:0] rb();
        logic [31:0] r;
        r = rnd();
        return {2'b01, r[5:0]};
    endfunction
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_beat(input logic [56:0] got, input logic [56:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: beat got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr <= 1'b0;
        case (a)
            SDP_REG_PKTLEN: plen = d[10:0];
            SDP_REG_DELIM: {d2, d1} = d[15:0];
            SDP_REG_OPTS: begin
                m2   = d[0];
                proc = d[2:1];
                dsel = d[6:5];
                chk  = d[4] ? 2'h3 : {1'b0, d[3]};
            end
            SDP_REG_LPORT: lp = d[15:0];
            default: if (a >= SDP_REG_DEST0 && a < SDP_REG_LPORT) dip[a[1:0]] = d;
        endcase
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        #1 chk_reg(reg_rdata, e);
    endtask
    task automatic cfg(input logic [10:0] l, input logic [15:0] dl, input logic [6:0] op);
        wr(SDP_REG_PKTLEN, {21'h0, l});
        wr(SDP_REG_DELIM, {16'h0, dl});
        wr(SDP_REG_OPTS, {25'h0, op});
    endtask
    // reference framing model, one call per byte sent
    task automatic send(input logic [7:0] b);
        logic hit;
        logic dm;
        sdp_host_inst.put(b);
        cnt++;
        hit = 1'b0;
        if (d1 == 8'h00 && d2 == 8'h00) hit = 1'b1;
        else if (tail > 0) begin
            tail--;
            hit = tail == 0;
        end else begin
            if (m2 && d1 != 8'h00 && d2 != 8'h00) dm = prv == d1 && b == d2;
            else dm = (d1 != 8'h00 && b == d1) || (d2 != 8'h00 && b == d2);
            if (dm && d1 != 8'h00 && proc != 0) tail = proc;
            else hit = dm;
        end
        hit = hit || (plen != 0 && cnt == plen) || cnt == SDP_BUF_BYTES;
        exq.push_back({chk, lp, dip[dsel], hit, b});
        if (hit) {cnt, tail} = '0;
        prv = b;
    endtask
    task automatic drain(input int lim);
        int k;
        for (k = 0; k < lim && (exq.size() != 0 || sdp_host_inst.busy()); k++) @(posedge clk_i);
        if (k == lim) begin
            n_fail++;
            $display("Error at %0t: beats left %h exp %h", $time, exq.size(), 0);
            conclude();
        end
    endtask
    ////////////////////////////
    // network side stalls one cycle in eight
    always @(posedge clk_i) begin
        cyc++;
        net_ready <= cyc[2:0] != 3'h3;
        if (!rst_i && net_valid && net_ready) begin
            if (exq.size() == 0) chk_beat({48'h0, beat.last, beat.data}, 57'h0);
            else begin
                ev = exq.pop_front();
                chk_beat({ev[58] ? beat.dest_port : 16'h0, ev[57] ? beat.dest_ip : 32'h0,
                    beat.last, beat.data}, {ev[58] ? ev[56:41] : 16'h0,
                    ev[57] ? ev[40:9] : 32'h0, ev[8:0]});
            end
        end
    end
    initial begin
        {rst_i, reg_addr, reg_wdata, reg_wr, reg_rd, net_ready} = {1'b1, 39'h0};
        {n_fail, n_checks, cyc, cnt, tail, proc, plen} = '0;
        {rs, d1, d2, prv, m2, chk, dsel, lp} = {32'h10, 24'h0, 1'b1, 4'h0, SDP_RST_LPORT};
        dip = '{4{32'h0}};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SDP_REG_PKTLEN, {21'h0, SDP_RST_PKTLEN});
        rd(SDP_REG_DELIM, {16'h0, SDP_RST_DELIM});
        rd(SDP_REG_OPTS, {25'h0, SDP_RST_OPTS});
        rd(SDP_REG_LPORT, {16'h0, SDP_RST_LPORT});
        rd(4'hF, 32'h0);
        cfg(11'h0, 16'h0, 7'h01);
        for (i = 0; i < 6; i++) send(8'(rnd()));
        drain(300);
        for (p = 0; p < 3; p++) begin
            for (i = 0; i < 2; i++) begin
                cfg(11'h0, 16'h0A0D, {4'h0, p[1:0], i[0]});
                send(rb());
                send(8'h0A);
                send(rb());
                send(8'h0D);
                send(8'h0A);
                repeat (p) send(rb());
                drain(300);
            end
        end
        cfg(11'h0, 16'h0A00, 7'h03);
        send(rb());
        send(8'h0A);
        send(8'h0A);
        drain(300);
        cfg(11'h3, 16'h0A0D, 7'h01);
        repeat (7) send(rb());
        send(8'h0D);
        send(8'h0A);
        drain(300);
        cfg(11'h0, 16'h0A0D, 7'h01);
        repeat (SDP_BUF_BYTES + 1) send(rb());
        send(8'h0D);
        send(8'h0A);
        drain(5000);
        wr(SDP_REG_FORCE, 32'h1);
        repeat (3) send(rb());
        exq.push_back({chk, lp, dip[dsel], 1'b1, 8'h00});
        cnt = 0;
        drain(SDP_MS_CYCLES + 2000);
        wr(SDP_REG_FORCE, 32'h0);
        send(rb());
        repeat (SDP_MS_CYCLES + 2000) @(posedge clk_i);
        send(8'h0D);
        send(8'h0A);
        drain(300);
        v = rnd();
        wr(4'h6, v);
        cfg(11'h0, 16'h0, 7'h49);
        send(rb());
        send(rb());
        drain(300);
        v = rnd();
        wr(SDP_REG_LPORT, {16'h0, v[15:0]});
        v = rnd();
        cfg(11'h0, 16'h0, 7'h19);
        sdp_host_inst.put(SDP_START_BYTE);
        for (i = 3; i >= 0; i--) sdp_host_inst.put(v[8*i +: 8]);
        sdp_host_inst.put(8'h00);
        sdp_host_inst.put(8'h03);
        for (i = 0; i < 3; i++) begin
            ev = {2'h3, lp, v, 1'b1, rb()};
            exq.push_back(ev);
            sdp_host_inst.put(ev[7:0]);
        end
        drain(300);
        rd(SDP_REG_CURIP, v);
        conclude();
    end
endmodule
`default_nettype wire
